// ---- link_ctrl_pkg.sv ----
// Package: register map, field layout, reset values and JESD link constants
// Notes on behaviour
// - Enable bit 0, one enables, resets one
// - Disabled: subsystem reset, serializers powered down
// - Disabled: subsystem clocks gated off
// - Disabled: counter reset, sysref ignored
// - Mode select bits 5:0, 7:6 reserved
// - Length register holds K minus one
// - Length register resets to thirty-one
// - 64b/66b modes use K = 256*E/F
// - Writing zero to soft sync requests sync
// - Soft sync works for any source
// - Stuck-low pin holds request until source two
// - Source two ignores every sync pin
package link_ctrl_pkg;
  // ****************************************************************
  // Register map (printed offsets are indexes; byte address is 4x)
  // ****************************************************************
  localparam logic [9:0] link_enable_ctrl_idx = 10'h200;
  localparam logic [9:0] link_mode_select_idx = 10'h201;
  localparam logic [9:0] multiframe_length_idx = 10'h202;
  localparam logic [9:0] software_sync_idx = 10'h203;
  localparam logic [9:0] sync_source_idx = 10'h204;
  localparam logic [9:0] link_status_idx = 10'h208;
  localparam int addr_w = 12;
  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int enable_bit = 0;
  localparam int mode_msb = 5;
  localparam int sync_bit = 0;
  localparam int sync_sel_lsb = 2;
  localparam logic [7:0] link_enable_rst = 8'h01;
  localparam logic [7:0] link_mode_rst = 8'h00;
  localparam logic [7:0] multiframe_length_rst = 8'h1f;
  localparam logic [7:0] software_sync_rst = 8'h01;
  localparam logic [1:0] sync_sel_rst = 2'h0;
  localparam logic [1:0] sync_sel_none = 2'h2;
  localparam logic [15:0] long_k_scale = 16'h0100;
  localparam logic [5:0] first_66b_mode = 6'h14;
endpackage : link_ctrl_pkg

// ---- sync_pair_if.sv ----
// Interface: raw pins into the synchroniser and clean levels out
`timescale 1ns/1ps
`default_nettype none
interface sync_pair_if;
  logic [1:0] raw;
  logic [1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : sync_pair_if
`default_nettype wire

// ---- pin_sync.sv ----
// Two flip-flop synchroniser for the sync pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  sync_pair_if.sync pins
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } sync_state_t;
  sync_state_t state_reg;
  sync_state_t state_next;
  // Idle high: pins are active low requests
  always_comb begin
    state_next = state_reg;
    state_next.meta = pins.raw;
    state_next.stable = state_reg.meta;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '{meta: 2'h3, stable: 2'h3};
    end else begin
      state_reg <= state_next;
    end
  end
  assign pins.clean = state_reg.stable;
endmodule : pin_sync
`default_nettype wire

// ---- link_ctrl_regs.sv ----
// Link control register bank on Avalon-MM with derived link controls
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_regs #(
  parameter int e_param = 1,
  parameter int f_param = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic sync_pin_se_n_i,
  input wire logic sync_pin_ts_n_i,
  input wire logic sysref_i,
  output logic link_reset_n_o,
  output logic serializer_power_down_o,
  output logic link_clock_enable_o,
  output logic [5:0] link_mode_select_o,
  output logic [8:0] effective_k_minus_one_o,
  output logic sync_request_n_o,
  output logic [8:0] multiframe_clock_counter_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum {bus_idle, bus_answer} bus_phase_t;
  typedef struct packed {
    logic link_enable;
    logic [5:0] link_mode_select;
    logic [7:0] multiframe_length_minus_one;
    logic soft_sync_request_n;
    logic [1:0] sync_source;
    logic [31:0] readdata;
    logic [1:0] response;
    logic answered;
    logic [8:0] counter;
    logic sysref_last;
    logic sysref_meta;
    logic sysref_sync;
    logic sync_n;
    logic [8:0] k_minus_one;
  } regs_state_t;
  regs_state_t state_reg;
  regs_state_t state_next;
  bus_phase_t phase_reg;
  bus_phase_t phase_next;
  sync_pair_if pins_if ();
  pin_sync pin_sync_inst (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pins(pins_if.sync)
  );
  assign pins_if.raw = {sync_pin_ts_n_i, sync_pin_se_n_i};
  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [9:0] word_idx;
  logic hit;
  logic [7:0] rd_byte;
  logic selected_pin_n;
  logic [15:0] long_k;
  logic is_long;
  assign word_idx = avs_address_i[11:2];
  assign long_k = 16'((int'(link_ctrl_pkg::long_k_scale) * e_param)
                      / f_param);
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    hit = 1'b1;
    rd_byte = 8'h00;
    is_long = (state_reg.link_mode_select >= link_ctrl_pkg::first_66b_mode);
    selected_pin_n = 1'b1;
    case (word_idx)
      link_ctrl_pkg::link_enable_ctrl_idx:
        rd_byte = {7'h00, state_reg.link_enable};
      link_ctrl_pkg::link_mode_select_idx:
        rd_byte = {2'h0, state_reg.link_mode_select};
      link_ctrl_pkg::multiframe_length_idx:
        rd_byte = state_reg.multiframe_length_minus_one;
      link_ctrl_pkg::software_sync_idx:
        rd_byte = {7'h00, state_reg.soft_sync_request_n};
      link_ctrl_pkg::sync_source_idx:
        rd_byte = {4'h0, state_reg.sync_source, 2'h0};
      link_ctrl_pkg::link_status_idx:
        rd_byte = {5'h00, state_reg.sync_n, state_reg.link_enable,
                   link_reset_n_o};
      default: hit = 1'b0;
    endcase
    // One wait cycle per access, then answer
    state_next.answered = 1'b0;
    case (phase_reg)
      bus_idle: begin
        if (avs_read_i || avs_write_i) begin
          phase_next = bus_answer;
          state_next.answered = 1'b1;
          state_next.readdata = {24'h000000, rd_byte};
          state_next.response = hit ? 2'h0 : 2'h3;
          if (avs_write_i && hit && avs_byteenable_i[0]) begin
            case (word_idx)
              link_ctrl_pkg::link_enable_ctrl_idx:
                state_next.link_enable = avs_writedata_i[0];
              link_ctrl_pkg::link_mode_select_idx:
                state_next.link_mode_select = avs_writedata_i[5:0];
              link_ctrl_pkg::multiframe_length_idx:
                state_next.multiframe_length_minus_one =
                  avs_writedata_i[7:0];
              link_ctrl_pkg::software_sync_idx:
                state_next.soft_sync_request_n = avs_writedata_i[0];
              link_ctrl_pkg::sync_source_idx:
                state_next.sync_source = avs_writedata_i[3:2];
              default: ;
            endcase
          end
        end
      end
      bus_answer: phase_next = bus_idle;
      default: phase_next = bus_idle;
    endcase
    // Pin choice; source two leaves only the soft bit
    case (state_reg.sync_source)
      2'h0: selected_pin_n = pins_if.clean[0];
      2'h1: selected_pin_n = pins_if.clean[1];
      default: selected_pin_n = 1'b1;
    endcase
    state_next.sync_n = state_reg.soft_sync_request_n
                        & selected_pin_n;
    // Long modes derive K from E and F, not the register
    state_next.k_minus_one = is_long ? 9'(long_k - 16'h0001)
      : {1'b0, state_reg.multiframe_length_minus_one};
    state_next.sysref_meta = sysref_i;
    state_next.sysref_sync = state_reg.sysref_meta;
    state_next.sysref_last = state_reg.sysref_sync;
    if (!state_reg.link_enable) begin
      state_next.counter = 9'h000;
    end else if (state_reg.sysref_sync && !state_reg.sysref_last) begin
      state_next.counter = 9'h000;
    end else if (state_reg.counter >= state_reg.k_minus_one) begin
      state_next.counter = 9'h000;
    end else begin
      state_next.counter = state_reg.counter + 9'h001;
    end
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= bus_idle;
      state_reg <= '0;
      state_reg.link_enable <= link_ctrl_pkg::link_enable_rst[0];
      state_reg.multiframe_length_minus_one <=
        link_ctrl_pkg::multiframe_length_rst;
      state_reg.soft_sync_request_n <= link_ctrl_pkg::software_sync_rst[0];
      state_reg.sync_source <= link_ctrl_pkg::sync_sel_rst;
      state_reg.sync_n <= 1'b1;
      state_reg.k_minus_one <= 9'h01f;
    end else begin
      phase_reg <= phase_next;
      state_reg <= state_next;
    end
  end
  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_waitrequest_o = (avs_read_i || avs_write_i)
                             && !state_reg.answered;
  assign avs_readdata_o = state_reg.readdata;
  assign avs_response_o = state_reg.response;
  // Gating done by the clock cell downstream; this is its enable
  assign link_reset_n_o = state_reg.link_enable;
  assign serializer_power_down_o = !state_reg.link_enable;
  assign link_clock_enable_o = state_reg.link_enable;
  assign link_mode_select_o = state_reg.link_mode_select;
  assign effective_k_minus_one_o = state_reg.k_minus_one;
  assign sync_request_n_o = state_reg.sync_n;
  assign multiframe_clock_counter_o = state_reg.counter;
endmodule : link_ctrl_regs
`default_nettype wire

// ---- link_ctrl_monitor.sv ----
// Checker for the link control register bank ports
`timescale 1ns/1ps
`default_nettype none
module link_ctrl_monitor #(
  parameter int e_param = 1,
  parameter int f_param = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic link_reset_n_o,
  input wire logic serializer_power_down_o,
  input wire logic link_clock_enable_o,
  input wire logic [5:0] link_mode_select_o,
  input wire logic [8:0] effective_k_minus_one_o,
  input wire logic sync_request_n_o,
  input wire logic [8:0] multiframe_clock_counter_o
);
  // Accepted write: flagged at the edge where waitrequest is low, one edge after the register bank stores it
  logic wr_ok;
  localparam logic [8:0] klong = 9'(256 * e_param / f_param - 1);
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_power: assert property (!link_reset_n_o |-> serializer_power_down_o)
    else $error("serializers powered while link held");
  a_clock_gate: assert property (link_clock_enable_o == link_reset_n_o)
    else $error("clock enable differs from link enable");
  a_counter_held: assert property (!link_clock_enable_o [*2] |->
    multiframe_clock_counter_o == 9'h000) else $error("counter runs");
  a_enable_on: assert property (wr_ok && avs_address_i == 12'h800 &&
    avs_writedata_i[0] |-> ##[0:2] link_reset_n_o) else $error("no enable");
  a_enable_off: assert property (wr_ok && avs_address_i == 12'h800 &&
    !avs_writedata_i[0] |-> ##[0:2] !link_clock_enable_o)
    else $error("no disable");
  a_soft_sync: assert property (wr_ok && avs_address_i == 12'h80c &&
    !avs_writedata_i[0] |-> ##[0:3] !sync_request_n_o)
    else $error("soft sync ignored");
  a_long_k: assert property ((link_mode_select_o >=
    link_ctrl_pkg::first_66b_mode) [*3] |-> effective_k_minus_one_o == klong)
    else $error("long mode K wrong");
  a_mode_reserved: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i == 12'h804 |-> avs_readdata_o[31:6] == 26'h0)
    else $error("mode reserved bits set");
endmodule : link_ctrl_monitor
bind link_ctrl_regs link_ctrl_monitor #(.e_param(e_param), .f_param(f_param))
  mon_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .link_reset_n_o(link_reset_n_o),
  .serializer_power_down_o(serializer_power_down_o),
  .link_clock_enable_o(link_clock_enable_o),
  .link_mode_select_o(link_mode_select_o),
  .effective_k_minus_one_o(effective_k_minus_one_o),
  .sync_request_n_o(sync_request_n_o),
  .multiframe_clock_counter_o(multiframe_clock_counter_o));
`default_nettype wire

// ---- sync_rx_model.sv ----
// Far-end receiver model: drives the active-low sync pins
`timescale 1ns/1ps
`default_nettype none
module sync_rx_model (
  input wire logic clk_i,
  input wire logic resync_i,
  input wire logic use_ts_i,
  output logic se_n_o,
  output logic ts_n_o
);
  // Idle pins sit high, as a released sync line would
  initial begin
    se_n_o = 1'b1;
    ts_n_o = 1'b1;
  end
  always @(posedge clk_i) begin
    se_n_o <= !(resync_i && !use_ts_i);
    ts_n_o <= !(resync_i && use_ts_i);
  end
endmodule : sync_rx_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the link control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] avs_address_i = 12'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic sysref_i = 1'b0;
  logic resync = 1'b0;
  logic use_ts = 1'b0;
  logic se_n, ts_n, wreq, rst_n, pd, ce, sync_n;
  logic [31:0] rdata, q;
  logic [1:0] resp, r;
  logic [5:0] mode;
  logic [8:0] keff, cnt;
  int miscompares = 0;
  int check_count = 0;
  always #12.5 clk_i = !clk_i;
  // Small E/F so the long-mode K differs from the default length
  link_ctrl_regs #(.e_param(2), .f_param(4)) dut_u (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .avs_response_o(resp),
    .sync_pin_se_n_i(se_n), .sync_pin_ts_n_i(ts_n), .sysref_i(sysref_i),
    .link_reset_n_o(rst_n), .serializer_power_down_o(pd),
    .link_clock_enable_o(ce), .link_mode_select_o(mode),
    .effective_k_minus_one_o(keff), .sync_request_n_o(sync_n),
    .multiframe_clock_counter_o(cnt));
  sync_rx_model rx_u (.clk_i(clk_i), .resync_i(resync), .use_ts_i(use_ts),
    .se_n_o(se_n), .ts_n_o(ts_n));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // Holds the request until the edge that sees waitrequest low
  task automatic bus(input logic we, input logic [11:0] a,
    input logic [7:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= we;
    avs_read_i <= !we;
    avs_writedata_i <= {24'h0, d};
    // Sample at the rising edge only; data is taken at that same edge
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (wreq === 1'b0) break;
    end
    if (n == 50) begin
      miscompares++;
      final_report();
    end
    q = rdata;
    r = resp;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic t_reset;
    bus(0, 12'h800, 0); chk(q, 32'h01);
    bus(0, 12'h804, 0); chk(q, 32'h00);
    bus(0, 12'h808, 0); chk(q, 32'h1f);
    bus(0, 12'h80c, 0); chk(q, 32'h01);
    $display("reset test done");
  endtask : t_reset
  task automatic t_disable;
    bus(1, 12'h800, 0); wt(3);
    chk({rst_n, pd, ce}, 3'b010);
    sysref_i <= 1'b1; wt(4); sysref_i <= 1'b0; wt(4);
    chk(cnt, 9'h000);
    $display("disable test done");
  endtask : t_disable
  task automatic t_mode;
    bus(1, 12'h804, 8'h3f);
    bus(0, 12'h804, 0); chk(q, 32'h3f);
    bus(1, 12'h808, 8'h07);
    bus(1, 12'h804, 8'h13); wt(3);
    chk(keff, 9'h007);
    bus(1, 12'h804, 8'h14); wt(3);
    chk(keff, 9'd127);
    chk(mode, 6'h14);
    bus(1, 12'h800, 1); wt(3);
    chk({rst_n, pd, ce}, 3'b101);
    $display("mode test done");
  endtask : t_mode
  task automatic t_sync;
    bus(1, 12'h80c, 0); wt(3); chk(sync_n, 1'b0);
    bus(1, 12'h80c, 1); wt(3); chk(sync_n, 1'b1);
    resync <= 1'b1; wt(5); chk(sync_n, 1'b0);
    bus(1, 12'h810, 8'h08); wt(5); chk(sync_n, 1'b1);
    bus(1, 12'h80c, 0); wt(3); chk(sync_n, 1'b0);
    bus(1, 12'h80c, 1); use_ts <= 1'b1;
    bus(1, 12'h810, 8'h04); wt(5); chk(sync_n, 1'b0);
    resync <= 1'b0; wt(5); chk(sync_n, 1'b1);
    bus(1, 12'h9fc, 8'h5a); bus(0, 12'h9fc, 0);
    chk(q, 32'h0); chk(r, 2'h3);
    $display("sync test done");
  endtask : t_sync
  initial begin
    wt(5);
    reset_n_i <= 1'b1;
    t_reset();
    t_disable();
    t_mode();
    t_sync();
    final_report();
  end
endmodule : tb
`default_nettype wire
